// ===== sbcr_cal_timer.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Calibration wait down-counter
// ----------------------------------------
module sbcr_cal_timer #(
    parameter int CW = 18
) (
    input  wire logic          pclk,     // Bus clock
    input  wire logic          presetn,  // Async reset, low
    input  wire logic          load,     // Start a new wait
    input  wire logic [CW-1:0] count,    // Cycles to wait
    output logic               done      // One-cycle end pulse
);

    logic [CW-1:0] cnt_r;   // Remaining cycles
    logic          run_r;   // Counting active
    logic          done_r;  // End pulse flop
    wire           last = run_r && (cnt_r == CW'(1));

    // Load, count down, flag the last cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r  <= '0;
            run_r  <= 1'b0;
            done_r <= 1'b0;
        end else begin
            cnt_r  <= load ? count : (run_r ? cnt_r - CW'(1) : cnt_r);
            run_r  <= load || (run_r && !last);
            done_r <= last && !load;
        end
    end

    assign done = done_r;

endmodule

`default_nettype wire

// ===== sbcr_consts.svh
`ifndef SBCR_CONSTS_SVH
`define SBCR_CONSTS_SVH

// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define SBCR_IDX_SWING       8'h18
`define SBCR_IDX_BIAS        8'h19
`define SBCR_IDX_GAIN        8'h1A
`define SBCR_IDX_CAL         8'h1B
`define SBCR_IDX_STATUS      8'h3F
`define SBCR_ADDR_SWING      8'h60
`define SBCR_ADDR_BIAS       8'h64
`define SBCR_ADDR_GAIN       8'h68
`define SBCR_ADDR_CAL        8'h6C
`define SBCR_ADDR_STATUS     8'hFC

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SBCR_RST_SWING       8'hE1
`define SBCR_RST_BIAS        8'h65
`define SBCR_RST_GAIN        8'h86
`define SBCR_RST_CAL         8'h05

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SBCR_PRE_HI          7
`define SBCR_PRE_LO          6
`define SBCR_RX_HI           5
`define SBCR_RX_LO           3
`define SBCR_TX_HI           2
`define SBCR_TX_LO           0
`define SBCR_CAL_START       7
`define SBCR_CAL_DUAL        6
`define SBCR_CAL_WAIT_HI     5
`define SBCR_CAL_WAIT_LO     4
`define SBCR_CAL_RSVD        3
`define SBCR_CAL_SEED_HI     2
`define SBCR_CAL_SEED_LO     0
`define SBCR_CAL_WMASK       8'hF7

// ----------------------------------------
// Calibration times in reference periods
// ----------------------------------------
`define SBCR_CAL_PER_0       18'h1_5F90
`define SBCR_CAL_PER_1       18'h1_ADB0
`define SBCR_CAL_PER_2       18'h1_FBD0
`define SBCR_CAL_PER_3       18'h3_0D40
`define SBCR_REF_CLKS        1

`endif

// ===== sbcr_host.sv
`timescale 1ns/1ps
`default_nettype none
// ------
// Host bus master model
// ------
module sbcr_host (
    input  wire logic        pclk,         // Clock
    input  wire logic [31:0] prdata,       // Read data
    input  wire logic        pready,       // Done
    input  wire logic        pslverr,      // Error
    output logic      [7:0]  paddr,        // Address
    output logic             psel,         // Select
    output logic             penable,      // Access
    output logic             pwrite,       // Direction
    output logic      [31:0] pwdata,       // Write data
    output logic      [3:0]  pstrb,        // Strobes
    output logic             main_freq_sel // Slot B
);
    logic timed_out = 1'b0; // Wait ran out
    // Idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pstrb = 4'hF;
        main_freq_sel = 1'b0;
    end
    // One transfer, request held until ready or 20 wait cycles
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        timed_out = (pready !== 1'b1);
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== sbcr_pkg.sv
// ----------------------------------------
// Types shared by the register group
// ----------------------------------------
package sbcr_pkg;

    // Calibration sequencer states
    typedef enum logic [1:0] {
        SBCR_ST_IDLE  = 2'b00,
        SBCR_ST_RUN   = 2'b01,
        SBCR_ST_STORE = 2'b10
    } sbcr_cal_state_t;

endpackage

// ===== sbcr_regs.sv
// What this block does
// [R01] Prescaler swing bits 7:6, reset three
// [R02] RX buffer swing bits 5:3, reset four
// [R03] TX buffer swing bits 2:0, reset one
// [R04] Prescaler current bits 7:6, reset one
// [R05] RX buffer current bits 5:3, reset four
// [R06] TX buffer current bits 2:0, reset five
// [R07] Loop gain byte resets to 134
// [R08] Start bit rising edge launches calibration when idle
// [R09] Dual bit stores both slots, else selected
// [R10] Wait code picks calibration length; bit3 reserved
// [R11] Software should pick the longest wait
// [R12] DAC seed equals code plus one
// [R13] All fields read back last written
`timescale 1ns/1ps
`default_nettype none
`include "sbcr_consts.svh"

module sbcr_regs
    import sbcr_pkg::*;
#(
    parameter int          CW      = 18,               // Wait counter width
    parameter int          REF_CLK = `SBCR_REF_CLKS,   // Clocks per ref period
    parameter logic [17:0] WAIT_0  = `SBCR_CAL_PER_0,  // Code 0 periods
    parameter logic [17:0] WAIT_1  = `SBCR_CAL_PER_1,  // Code 1 periods
    parameter logic [17:0] WAIT_2  = `SBCR_CAL_PER_2,  // Code 2 periods
    parameter logic [17:0] WAIT_3  = `SBCR_CAL_PER_3   // Code 3 periods
) (
    input  wire logic        pclk,          // Bus clock, 40 MHz
    input  wire logic        presetn,       // Async reset, low
    input  wire logic [7:0]  paddr,         // Byte address
    input  wire logic        psel,          // Slave select
    input  wire logic        penable,       // Access phase
    input  wire logic        pwrite,        // Write when high
    input  wire logic [31:0] pwdata,        // Write data
    input  wire logic [3:0]  pstrb,         // Byte strobes
    output logic      [31:0] prdata,        // Read data
    output logic             pready,        // Transfer done
    output logic             pslverr,       // Unmapped address or status write
    input  wire logic        main_freq_sel, // Selected slot, B when high
    output logic      [1:0]  pre_swing,     // Prescaler swing code
    output logic      [2:0]  rx_swing,      // RX LO buffer swing
    output logic      [2:0]  tx_swing,      // TX LO buffer swing
    output logic      [1:0]  pre_current,   // Prescaler current code
    output logic      [2:0]  rx_current,    // RX LO buffer current
    output logic      [2:0]  tx_current,    // TX LO buffer current
    output logic      [7:0]  loop_gain,     // Charge-pump scaling
    output logic      [3:0]  cal_dac_seed,  // DAC start value 1..8
    output logic             cal_busy,      // Calibration running
    output logic             cal_store_a,   // Store results in A
    output logic             cal_store_b    // Store results in B
);

    // ----------------------------------------
    // Functions
    // ----------------------------------------

    // Wait code to clock count
    function automatic logic [CW-1:0] wait_cycles(input logic [1:0] code);
        logic [17:0] per;
        per = WAIT_0;
        case (code)
            2'b00:   per = WAIT_0;
            2'b01:   per = WAIT_1;
            2'b10:   per = WAIT_2;
            2'b11:   per = WAIT_3;
            default: per = WAIT_0;
        endcase
        wait_cycles = CW'(per * REF_CLK);
    endfunction

    // Full byte address match
    function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_a);
        hit = (a == reg_a);
    endfunction

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [7:0]       swing_r;     // Swing register
    logic [7:0]       bias_r;      // Bias register
    logic [7:0]       gain_r;      // Loop gain register
    logic [7:0]       cal_r;       // Calibration control
    logic [31:0]      prdata_r;    // Read data flop
    logic             pready_r;    // Ready flop
    logic             pslverr_r;   // Error flop
    logic [3:0]       seed_r;      // Seed output flop
    logic             busy_r;      // Busy output flop
    logic             dual_r;      // Dual captured at launch
    logic             sel_r;       // Slot captured at launch
    logic [1:0]       wcode_r;     // Wait code at launch
    sbcr_cal_state_t  st_r;        // Sequencer state
    sbcr_cal_state_t  st_nxt;      // Next state

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire setup    = psel && !penable;              // Setup phase
    wire access   = psel && penable && pready_r;   // Completing access
    wire wr_ok    = access && pwrite && !pslverr_r && pstrb[0];
    wire sel_sw   = hit(paddr, `SBCR_ADDR_SWING);  // Swing selected
    wire sel_bi   = hit(paddr, `SBCR_ADDR_BIAS);   // Bias selected
    wire sel_gn   = hit(paddr, `SBCR_ADDR_GAIN);   // Gain selected
    wire sel_cl   = hit(paddr, `SBCR_ADDR_CAL);    // Cal ctrl selected
    wire sel_st   = hit(paddr, `SBCR_ADDR_STATUS); // Status selected
    wire mapped   = sel_sw || sel_bi || sel_gn || sel_cl || sel_st;
    wire bad_wr   = pwrite && sel_st;              // Status is read-only
    wire [7:0] wb = pwdata[7:0];                   // Low lane data

    // Status word: busy and captured routing
    wire [7:0] status = {4'h0, dual_r, sel_r, 1'b0, busy_r};

    // Read mux
    wire [7:0] rd_byte = sel_sw ? swing_r :
                         sel_bi ? bias_r  :
                         sel_gn ? gain_r  :
                         sel_cl ? cal_r   :
                         sel_st ? status  : 8'h00;

    // ----------------------------------------
    // Calibration launch
    // ----------------------------------------
    // [R08] Detect rising start bit
    wire start_new = wr_ok && sel_cl && wb[`SBCR_CAL_START];
    wire start_old = cal_r[`SBCR_CAL_START];
    wire launch    = start_new && !start_old && (st_r == SBCR_ST_IDLE);
    wire tmr_done;                                 // Wait ended

    // ----------------------------------------
    // APB response
    // ----------------------------------------

    // Answer one cycle after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
        end else begin
            pready_r <= setup;
        end
    end

    // Capture read data and error in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (setup) begin
            prdata_r  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            pslverr_r <= !mapped || bad_wr;
        end else begin
            pslverr_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------

    // [R01] Swing register with reset value
    // [R13] Holds last write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            swing_r <= `SBCR_RST_SWING;
        end else if (wr_ok && sel_sw) begin
            swing_r <= wb;
        end
    end

    // [R04] Bias register with reset value
    // [R13] Holds last write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bias_r <= `SBCR_RST_BIAS;
        end else if (wr_ok && sel_bi) begin
            bias_r <= wb;
        end
    end

    // [R07] Loop gain resets to 134
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gain_r <= `SBCR_RST_GAIN;
        end else if (wr_ok && sel_gn) begin
            gain_r <= wb;
        end
    end

    // [R10] Control register, reserved bit held zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_r <= `SBCR_RST_CAL;
        end else if (wr_ok && sel_cl) begin
            cal_r <= wb & `SBCR_CAL_WMASK;
        end
    end

    // ----------------------------------------
    // Calibration sequencer
    // ----------------------------------------

    // Next state
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            SBCR_ST_IDLE: begin
                if (launch) begin
                    st_nxt = SBCR_ST_RUN;
                end
            end
            SBCR_ST_RUN: begin
                if (tmr_done) begin
                    st_nxt = SBCR_ST_STORE;
                end
            end
            SBCR_ST_STORE: begin
                st_nxt = SBCR_ST_IDLE;
            end
            default: begin
                st_nxt = SBCR_ST_IDLE;
            end
        endcase
    end

    // State flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= SBCR_ST_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // [R09] Capture routing at launch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dual_r  <= 1'b0;
            sel_r   <= 1'b0;
            wcode_r <= 2'b00;
        end else if (launch) begin
            dual_r  <= wb[`SBCR_CAL_DUAL];
            sel_r   <= main_freq_sel;
            wcode_r <= wb[`SBCR_CAL_WAIT_HI:`SBCR_CAL_WAIT_LO];
        end
    end

    // Busy from launch until results stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= (st_nxt != SBCR_ST_IDLE);
        end
    end

    // [R12] Seed is code plus one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seed_r <= 4'h0;
        end else begin
            seed_r <= {1'b0, st_r == SBCR_ST_IDLE && launch
                ? wb[`SBCR_CAL_SEED_HI:`SBCR_CAL_SEED_LO]
                : cal_r[`SBCR_CAL_SEED_HI:`SBCR_CAL_SEED_LO]} + 4'h1;
        end
    end

    // ----------------------------------------
    // Submodules
    // ----------------------------------------

    // [R10] Wait length from code
    sbcr_cal_timer #(
        .CW      (CW)
    ) u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (launch),
        .count   (wait_cycles(wb[`SBCR_CAL_WAIT_HI:`SBCR_CAL_WAIT_LO])),
        .done    (tmr_done)
    );

    // [R09] Steer results to slots
    sbcr_slot_route u_route (
        .pclk    (pclk),
        .presetn (presetn),
        .fire    (st_r == SBCR_ST_STORE),
        .dual    (dual_r),
        .sel_b   (sel_r),
        .store_a (cal_store_a),
        .store_b (cal_store_b)
    );

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign prdata       = prdata_r;
    assign pready       = pready_r;
    assign pslverr      = pslverr_r;
    // [R01] Prescaler swing field
    assign pre_swing    = swing_r[`SBCR_PRE_HI:`SBCR_PRE_LO];
    // [R02] RX swing field
    assign rx_swing     = swing_r[`SBCR_RX_HI:`SBCR_RX_LO];
    // [R03] TX swing field
    assign tx_swing     = swing_r[`SBCR_TX_HI:`SBCR_TX_LO];
    // [R04] Prescaler current field
    assign pre_current  = bias_r[`SBCR_PRE_HI:`SBCR_PRE_LO];
    // [R05] RX current field
    assign rx_current   = bias_r[`SBCR_RX_HI:`SBCR_RX_LO];
    // [R06] TX current field
    assign tx_current   = bias_r[`SBCR_TX_HI:`SBCR_TX_LO];
    // [R07] Gain to charge pump
    assign loop_gain    = gain_r;
    assign cal_dac_seed = seed_r;
    assign cal_busy     = busy_r;

endmodule

`default_nettype wire

// ===== sbcr_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ------
// Register group checks
// ------
module sbcr_regs_chk (
    input wire logic        pclk,          // Clock
    input wire logic        presetn,       // Reset, low
    input wire logic [7:0]  paddr,         // Address
    input wire logic        psel,          // Select
    input wire logic        penable,       // Access
    input wire logic        pwrite,        // Write
    input wire logic [31:0] pwdata,        // Write data
    input wire logic [3:0]  pstrb,         // Strobes
    input wire logic [31:0] prdata,        // Read data
    input wire logic        pready,        // Done
    input wire logic        pslverr,       // Error
    input wire logic        main_freq_sel, // Slot B
    input wire logic [1:0]  pre_swing,     // Swing
    input wire logic [2:0]  rx_swing,      // Swing
    input wire logic [2:0]  tx_swing,      // Swing
    input wire logic [1:0]  pre_current,   // Current
    input wire logic [2:0]  rx_current,    // Current
    input wire logic [2:0]  tx_current,    // Current
    input wire logic [7:0]  loop_gain,     // Gain
    input wire logic [3:0]  cal_dac_seed,  // Seed
    input wire logic        cal_busy,      // Busy
    input wire logic        cal_store_a,   // Store A
    input wire logic        cal_store_b    // Store B
);
    localparam int CAL_MAX = 20; // Longest wait plus pipeline
    logic start_r; // Stored start bit
    logic dual_r;  // Dual at launch
    logic sel_r;   // Slot at launch
    wire  wr_go  = psel && penable && pready && pwrite && pstrb[0];
    wire  wr_cal = wr_go && (paddr == 8'h6C);
    wire  launch = wr_cal && pwdata[7] && !start_r && !cal_busy;
    wire  mapped = paddr == 8'h60 || paddr == 8'h64 || paddr == 8'h68
                   || paddr == 8'h6C || paddr == 8'hFC;
    // Shadow of launch state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_r <= 1'b0;
            dual_r  <= 1'b0;
            sel_r   <= 1'b0;
        end else begin
            if (wr_cal) begin
                start_r <= pwdata[7];
            end
            if (launch) begin
                dual_r <= pwdata[6];
                sel_r  <= main_freq_sel;
            end
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence cal_end_s;
        cal_store_a || cal_store_b;
    endsequence
    rdy_after_setup_a: assert property (setup_s |=> pready)
        else $error("no ready after setup");
    rdy_in_access_a: assert property (pready |-> penable && $past(psel && !penable))
        else $error("ready outside access");
    err_unmapped_a: assert property (setup_s and !mapped |=> pslverr)
        else $error("unmapped not refused");
    swing_wr_a: assert property (wr_go && paddr == 8'h60 |=>
        {pre_swing, rx_swing, tx_swing} == $past(pwdata[7:0])) else $error("swing");
    bias_wr_a: assert property (wr_go && paddr == 8'h64 |=>
        {pre_current, rx_current, tx_current} == $past(pwdata[7:0])) else $error("bias");
    gain_wr_a: assert property (wr_go && paddr == 8'h68 |=>
        loop_gain == $past(pwdata[7:0])) else $error("gain");
    seed_track_a: assert property (wr_cal |=> ##1
        cal_dac_seed == 4'($past(pwdata[2:0], 2)) + 4'h1) else $error("seed");
    launch_busy_a: assert property (launch |=> cal_busy)
        else $error("no busy on launch");
    cal_len_a: assert property (launch |-> ##[3:CAL_MAX] cal_end_s)
        else $error("calibration too long");
    slot_pick_a: assert property (cal_end_s |-> cal_store_a == (dual_r || !sel_r)
        && cal_store_b == (dual_r || sel_r)) else $error("wrong slot");
    busy_end_a: assert property (cal_end_s |=> !cal_busy)
        else $error("busy stays");
    idle_quiet_a: assert property (!$past(cal_busy) |-> !cal_store_a && !cal_store_b)
        else $error("store while idle");
endmodule
bind sbcr_regs sbcr_regs_chk chk (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .main_freq_sel(main_freq_sel), .pre_swing(pre_swing),
    .rx_swing(rx_swing), .tx_swing(tx_swing), .pre_current(pre_current),
    .rx_current(rx_current), .tx_current(tx_current), .loop_gain(loop_gain),
    .cal_dac_seed(cal_dac_seed), .cal_busy(cal_busy), .cal_store_a(cal_store_a),
    .cal_store_b(cal_store_b)
);
`default_nettype wire

// ===== sbcr_slot_route.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Result slot steering
// ----------------------------------------
module sbcr_slot_route (
    input  wire logic pclk,     // Bus clock
    input  wire logic presetn,  // Async reset, low
    input  wire logic fire,     // Store results now
    input  wire logic dual,     // Store in both slots
    input  wire logic sel_b,    // Selected slot is B
    output logic      store_a,  // Write slot A pulse
    output logic      store_b   // Write slot B pulse
);

    logic a_r;  // Slot A pulse flop
    logic b_r;  // Slot B pulse flop

    // Dual stores both, else only the selected slot
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_r <= 1'b0;
            b_r <= 1'b0;
        end else begin
            a_r <= fire && (dual || !sel_b);
            b_r <= fire && (dual || sel_b);
        end
    end

    assign store_a = a_r;
    assign store_b = b_r;

endmodule

`default_nettype wire

// ===== tb_synth_buffer_cal_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_synth_buffer_cal_regs import sbcr_pkg::*;;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] q; logic e;} sbcr_row_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr, loop_gain, sw, bi, ga, cc;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb, cal_dac_seed;
    logic [2:0] rx_swing, tx_swing, rx_current, tx_current;
    logic [1:0] pre_swing, pre_current;
    logic psel, penable, pwrite, pready, pslverr, main_freq_sel;
    logic cal_busy, cal_store_a, cal_store_b, sa, sb;
    int n_mismatch = 0;
    int checked = 0;
    int cyc = 0;
    int n_st = 0;
    int t_st = 0;
    int dur[4];
    localparam logic [17:0] WT [4] = '{18'h0_0006, 18'h0_0008, 18'h0_000A, 18'h0_0010};
    sbcr_row_t rows[7] = '{'{8'h60, 8'hB2, 8'hB2, 1'b0}, '{8'h60, 8'h00, 8'h00, 1'b0},
        '{8'h64, 8'h5B, 8'h5B, 1'b0}, '{8'h68, 8'hAE, 8'hAE, 1'b0},
        '{8'h6C, 8'h3C, 8'h34, 1'b0}, '{8'h6C, 8'h07, 8'h07, 1'b0},
        '{8'h10, 8'hFF, 8'h00, 1'b1}};
    always #12.5 pclk = ~pclk;
    sbcr_host host (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pstrb(pstrb), .main_freq_sel(main_freq_sel));
    sbcr_regs #(.WAIT_0(WT[0]), .WAIT_1(WT[1]), .WAIT_2(WT[2]),
        .WAIT_3(WT[3])) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .main_freq_sel(main_freq_sel),
        .pre_swing(pre_swing), .rx_swing(rx_swing), .tx_swing(tx_swing),
        .pre_current(pre_current), .rx_current(rx_current), .tx_current(tx_current),
        .loop_gain(loop_gain), .cal_dac_seed(cal_dac_seed), .cal_busy(cal_busy),
        .cal_store_a(cal_store_a), .cal_store_b(cal_store_b));
    // Cycle count and store pulse log
    always @(posedge pclk) begin
        cyc++;
        if (cal_store_a === 1'b1 || cal_store_b === 1'b1) begin
            n_st++;
            t_st = cyc;
            sa = cal_store_a;
            sb = cal_store_b;
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // Bus access, hang cut short
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q, output logic e);
        host.xfer(w, a, d, q, e);
        if (host.timed_out) begin
            n_mismatch++;
            final_report();
        end
    endtask
    // Launch one calibration and time it
    task automatic cal_run(input logic [1:0] c, input logic du, input logic s, input bit bw);
        logic [7:0] q;
        logic e;
        int k;
        int t0;
        int n0;
        @(posedge pclk);
        host.main_freq_sel <= s;
        bus(1'b1, 8'h6C, {2'b00, c, 4'h4}, q, e);
        n0 = n_st;
        bus(1'b1, 8'h6C, {1'b1, du, c, 4'h4}, q, e);
        @(negedge pclk);
        t0 = cyc;
        chk({7'h00, cal_busy}, 8'h01);
        if (bw) begin
            bus(1'b1, 8'h6C, 8'h34, q, e);
            bus(1'b1, 8'h6C, 8'hB4, q, e);
        end
        for (k = 0; k < 60 && n_st == n0; k++) @(posedge pclk);
        if (k == 60) begin
            n_mismatch++;
            final_report();
        end
        chk({6'h00, sa, sb}, {6'h00, du | ~s, du | s});
        dur[c] = t_st - t0;
        $display("calibration code %0d done", c);
    endtask
    initial begin
        logic [7:0] q;
        logic e;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        sw = 8'hE1;
        bi = 8'h65;
        ga = 8'h86;
        cc = 8'h05;
        foreach (rows[i]) begin
            bus(1'b1, rows[i].a, rows[i].d, q, e);
            chk({7'h00, e}, {7'h00, rows[i].e});
            bus(1'b0, rows[i].a, 8'h00, q, e);
            chk(q, rows[i].q);
            chk({7'h00, e}, {7'h00, rows[i].e});
            case (rows[i].a)
                8'h60: sw = rows[i].d;
                8'h64: bi = rows[i].d;
                8'h68: ga = rows[i].d;
                8'h6C: cc = rows[i].d & 8'hF7;
                default: ;
            endcase
            chk({pre_swing, rx_swing, tx_swing}, sw);
            chk({pre_current, rx_current, tx_current}, bi);
            chk(loop_gain, ga);
            chk({4'h0, cal_dac_seed}, {5'h00, cc[2:0]} + 8'h01);
        end
        $display("register rows done");
        cal_run(2'd0, 1'b0, 1'b0, 1'b0);
        cal_run(2'd1, 1'b0, 1'b1, 1'b0);
        cal_run(2'd2, 1'b1, 1'b0, 1'b0);
        cal_run(2'd3, 1'b1, 1'b1, 1'b1);
        chk(8'(dur[0]), 8'(WT[0] + 3));
        for (int i = 1; i < 4; i++) chk(8'(dur[i] - dur[0]), 8'(WT[i] - WT[0]));
        bus(1'b0, 8'h6C, 8'h00, q, e);
        chk(q, 8'hB4);
        repeat (40) @(posedge pclk);
        chk(8'(n_st), 8'h04);
        chk({7'h00, cal_busy}, 8'h00);
        $display("calibration done");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, {4'h6, 2'(i), 2'b00}, 8'h00, q, e);
            chk(q, i == 0 ? 8'hE1 : i == 1 ? 8'h65 : i == 2 ? 8'h86 : 8'h05);
        end
        chk({pre_swing, rx_swing, tx_swing}, 8'hE1);
        chk({pre_current, rx_current, tx_current}, 8'h65);
        chk(loop_gain, 8'h86);
        chk({4'h0, cal_dac_seed}, 8'h06);
        $display("reset defaults done");
        final_report();
    end
endmodule
`default_nettype wire
